// file: rtl/interrupt_priority_event_coder.sv
// Interrupt priority resolver and event code generator.
`timescale 1ns/10ps

module interrupt_priority_event_coder #(
  parameter bit FIXED_PIN_LEVELS = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // External requests
  input  wire logic        nmiReq,
  input  wire logic [3:0]  request_pins,
  // On-chip module requests
  input  wire logic        debug_interface,
  input  wire logic        port_unit_request,
  input  wire logic [7:0]  dma_transfer_end,
  input  wire logic        dma_address_error,
  input  wire logic [4:0]  timer_underflow,
  input  wire logic        timer_input_capture,
  input  wire logic        clock_alarm,
  input  wire logic        clock_periodic,
  input  wire logic        clock_carry_up,
  input  wire logic [3:0]  serialReq,
  input  wire logic [3:0]  fifoSerialReq,
  input  wire logic        watchdog_interval,
  input  wire logic        refresh_compare_match,
  input  wire logic        refresh_counter_overflow,
  // Register access
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [2:0]  regSelect,
  input  wire logic [15:0] regWriteData,
  output logic      [15:0] regReadData,
  // Processor core side
  input  wire logic        irqAccept,
  output logic             irqValid,
  output logic      [4:0]  irqLevel,
  output logic      [11:0] irqCode,
  output logic      [11:0] event_code_register,
  output logic      [31:0] handlerVector
);

  localparam int N = interrupt_priority_pkg::NUM_SRC;

  // ---------------------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------------------
  logic [3:0] pinMeta;
  logic [3:0] pins;

  // The pins are asynchronous; only the second stage is used downstream.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= interrupt_priority_pkg::PINS_IDLE;
      pins    <= interrupt_priority_pkg::PINS_IDLE;
    end else begin
      pinMeta <= request_pins;
      pins    <= pinMeta;
    end
  end

  // ---------------------------------------------------------------------------
  // Programmed and active priority registers
  // ---------------------------------------------------------------------------
  logic [15:0] priority_reg_a;
  logic [15:0] priority_reg_b;
  logic [15:0] priority_reg_c;
  logic [15:0] priority_reg_d;
  logic [15:0] extended_priority_reg;
  logic        pin_mode_select;
  logic [15:0] actA;
  logic [15:0] actB;
  logic [15:0] actC;
  logic [15:0] actD;
  logic [15:0] actExt;

  // Software writes land here; reserved low nibble of B stays zero.
  // programmed group levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      priority_reg_a        <= interrupt_priority_pkg::PRIO_RST;
      priority_reg_b        <= interrupt_priority_pkg::PRIO_RST;
      priority_reg_c        <= interrupt_priority_pkg::PRIO_RST;
      priority_reg_d        <= interrupt_priority_pkg::PRIO_D_RST;
      extended_priority_reg <= interrupt_priority_pkg::PRIO_RST;
      pin_mode_select       <= 1'b0;
    end else if (regWrite) begin
      if (regSelect == interrupt_priority_pkg::SEL_PRIO_A) begin
        priority_reg_a <= regWriteData;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_B) begin
        priority_reg_b <= regWriteData & interrupt_priority_pkg::PRIO_B_MASK;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_C) begin
        priority_reg_c <= regWriteData;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_D) begin
        priority_reg_d <= regWriteData;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_EXT) begin
        extended_priority_reg <= regWriteData;
      end else if (regSelect == interrupt_priority_pkg::SEL_CONTROL) begin
        pin_mode_select <= regWriteData[interrupt_priority_pkg::PIN_MODE_BIT];
      end
    end
  end

  // Arbitration runs on the active copy, refreshed by a register read. Software
  // must read back after writing all the levels, so a half-written set of
  // levels never races with acceptance.
  // read applies levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      actA   <= interrupt_priority_pkg::PRIO_RST;
      actB   <= interrupt_priority_pkg::PRIO_RST;
      actC   <= interrupt_priority_pkg::PRIO_RST;
      actD   <= interrupt_priority_pkg::PRIO_D_RST;
      actExt <= interrupt_priority_pkg::PRIO_RST;
    end else if (regRead) begin
      actA   <= priority_reg_a;
      actB   <= priority_reg_b;
      actC   <= priority_reg_c;
      actD   <= FIXED_PIN_LEVELS ? interrupt_priority_pkg::PRIO_D_RST : priority_reg_d;
      actExt <= extended_priority_reg;
    end
  end

  // Read data; unused selects return zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regReadData <= '0;
    end else if (regRead) begin
      if (regSelect == interrupt_priority_pkg::SEL_PRIO_A) begin
        regReadData <= priority_reg_a;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_B) begin
        regReadData <= priority_reg_b;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_C) begin
        regReadData <= priority_reg_c;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_D) begin
        regReadData <= priority_reg_d;
      end else if (regSelect == interrupt_priority_pkg::SEL_PRIO_EXT) begin
        regReadData <= extended_priority_reg;
      end else if (regSelect == interrupt_priority_pkg::SEL_CONTROL) begin
        regReadData <= {8'h00, pin_mode_select, 7'h00};
      end else begin
        regReadData <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Source table
  // ---------------------------------------------------------------------------
  logic [N-1:0]        req;
  logic [N-1:0][4:0]   lvl;
  logic [11:0]         irlCode;

  // Encoded pin code is base plus value times step.
  // encoded pin code
  assign irlCode = interrupt_priority_pkg::IRL_BASE + {3'h0, pins, 5'h00};

  // Zero-extended 4-bit fields; a zero field masks the whole group.
  // default group order
  always_comb begin
    req[0]  = nmiReq;
    lvl[0]  = interrupt_priority_pkg::LVL_NMI;
    req[1]  = !pin_mode_select && (pins != interrupt_priority_pkg::PINS_IDLE);
    lvl[1]  = {1'b0, ~pins};
    for (int p = 0; p < 4; p++) begin
      req[2+p] = pin_mode_select && !pins[p];
      lvl[2+p] = {1'b0, actD[15-4*p -: 4]};
    end
    req[6]  = debug_interface;
    lvl[6]  = {1'b0, actC[3:0]};
    req[7]  = port_unit_request;
    lvl[7]  = {1'b0, actC[15:12]};
    for (int d = 0; d < 8; d++) begin
      req[8+d] = dma_transfer_end[d];
      lvl[8+d] = {1'b0, actC[11:8]};
    end
    req[16] = dma_address_error;
    lvl[16] = {1'b0, actC[11:8]};
    req[17] = timer_underflow[3];
    lvl[17] = {1'b0, actExt[11:8]};
    req[18] = timer_underflow[4];
    lvl[18] = {1'b0, actExt[15:12]};
    req[19] = timer_underflow[0];
    lvl[19] = {1'b0, actA[15:12]};
    req[20] = timer_underflow[1];
    lvl[20] = {1'b0, actA[11:8]};
    req[21] = timer_underflow[2];
    lvl[21] = {1'b0, actA[7:4]};
    req[22] = timer_input_capture;
    lvl[22] = {1'b0, actA[7:4]};
    req[23] = clock_alarm;
    req[24] = clock_periodic;
    req[25] = clock_carry_up;
    for (int r = 23; r < 26; r++) begin
      lvl[r] = {1'b0, actA[3:0]};
    end
    for (int s = 0; s < 4; s++) begin
      req[26+s] = serialReq[s];
      lvl[26+s] = {1'b0, actB[7:4]};
      req[30+s] = fifoSerialReq[s];
      lvl[30+s] = {1'b0, actC[7:4]};
    end
    req[34] = watchdog_interval;
    lvl[34] = {1'b0, actB[15:12]};
    req[35] = refresh_compare_match;
    req[36] = refresh_counter_overflow;
    lvl[35] = {1'b0, actB[11:8]};
    lvl[36] = {1'b0, actB[11:8]};
  end

  // ---------------------------------------------------------------------------
  // Winner selection and outputs
  // ---------------------------------------------------------------------------
  logic       found;
  logic [5:0] winIdx;
  logic [4:0] winLevel;
  logic [11:0] next_code;

  source_priority_select u_select (
    .req      (req),
    .level    (lvl),
    .found    (found),
    .winIdx   (winIdx),
    .winLevel (winLevel)
  );

  assign next_code = (winIdx == 6'd1) ? irlCode : interrupt_priority_pkg::SRC_CODE[winIdx];

  // Re-evaluated every cycle so level or request changes show one cycle later.
  // present highest request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqValid <= 1'b0;
      irqLevel <= '0;
      irqCode  <= '0;
    end else begin
      irqValid <= found;
      irqLevel <= winLevel;
      irqCode  <= found ? next_code : 12'h000;
    end
  end

  // Acceptance latches the code; every source lands on the same handler.
  // common handler vector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_code_register <= '0;
      handlerVector       <= '0;
    end else if (irqAccept && irqValid) begin
      event_code_register <= irqCode;
      handlerVector       <= interrupt_priority_pkg::HANDLER_VEC;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  logic tieBroken;

  // Helper: an earlier unmasked request at or above the winning level.
  always_comb begin
    tieBroken = 1'b0;
    for (int k = 0; k < N; k++) begin
      if ((k < int'(winIdx)) && req[k] && (lvl[k] != 5'h00) && (lvl[k] >= winLevel)) begin
        tieBroken = 1'b1;
      end
    end
  end

  a_nmi_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nmiReq |=> irqValid && (irqCode == 12'h1c0) && (irqLevel == 5'h10))
    else $error("nmi not reported at level 16");

  a_encoded_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!nmiReq && !pin_mode_select && (pins == 4'h2) && !(|req[N-1:6]))
      |=> (irqCode == 12'h240) && (irqLevel == 5'hd))
    else $error("encoded pin value 2 mapped wrongly");

  a_indep_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!nmiReq && pin_mode_select && (pins == 4'b0111) && (actD[3:0] == 4'hf))
      |=> (irqCode == 12'h360) && (irqLevel == 5'hf))
    else $error("independent pin 3 mapped wrongly");

  a_mask_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irqValid |-> (irqLevel != 5'h00))
    else $error("masked level presented");

  a_tie_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    found |-> !tieBroken)
    else $error("later source won over earlier equal level");

  a_code_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqAccept && irqValid) |=> (event_code_register == $past(irqCode)))
    else $error("event code not captured");

  a_vector_common: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqAccept && irqValid) |=> (handlerVector == 32'h0000_0600))
    else $error("handler vector differs");

  a_read_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (regRead && !regWrite) |=> (actA == $past(priority_reg_a)) && (actC == $past(priority_reg_c)))
    else $error("read did not apply levels");

  a_idle_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(|req) |=> !irqValid ##1 1'b1)
    else $error("request shown with nothing pending");

endmodule

// file: rtl/interrupt_priority_pkg.sv
// Shared constants for the interrupt priority and event code block.
package interrupt_priority_pkg;

  // ---------------------------------------------------------------------------
  // Source table sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_SRC = 37;
  localparam int LVL_W   = 5;
  localparam int CODE_W  = 12;
  localparam int IDX_W   = 6;

  // ---------------------------------------------------------------------------
  // Levels and pin encoding
  // ---------------------------------------------------------------------------
  localparam logic [LVL_W-1:0]  LVL_NMI      = 5'h10;
  localparam logic [3:0]        PINS_IDLE    = 4'hf;
  localparam logic [CODE_W-1:0] IRL_BASE     = 12'h200;
  localparam logic [CODE_W-1:0] IRL_STEP     = 12'h020;
  localparam logic [31:0]       HANDLER_VEC  = 32'h0000_0600;

  // ---------------------------------------------------------------------------
  // Register selects, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  SEL_PRIO_A   = 3'h0;
  localparam logic [2:0]  SEL_PRIO_B   = 3'h1;
  localparam logic [2:0]  SEL_PRIO_C   = 3'h2;
  localparam logic [2:0]  SEL_PRIO_D   = 3'h3;
  localparam logic [2:0]  SEL_PRIO_EXT = 3'h4;
  localparam logic [2:0]  SEL_CONTROL  = 3'h5;
  localparam int          PIN_MODE_BIT = 7;
  localparam logic [15:0] PRIO_RST     = 16'h0000;
  localparam logic [15:0] PRIO_D_RST   = 16'hda74;
  localparam logic [15:0] PRIO_B_MASK  = 16'hfff0;

  // ---------------------------------------------------------------------------
  // Event codes, indexed in default order (index 0 ranks highest)
  // ---------------------------------------------------------------------------
  localparam logic [CODE_W-1:0] SRC_CODE [NUM_SRC] = '{
    12'h1c0, 12'h200, 12'h240, 12'h2a0, 12'h300, 12'h360,   // nmi, irl
    12'h600, 12'h620,                                       // debug, port
    12'h640, 12'h660, 12'h680, 12'h6a0,                     // dma end 0-3
    12'h780, 12'h7a0, 12'h7c0, 12'h7e0, 12'h6c0,            // dma end 4-7, err
    12'hb00, 12'hb80, 12'h400, 12'h420, 12'h440, 12'h460,   // timers
    12'h480, 12'h4a0, 12'h4c0,                              // clock unit
    12'h4e0, 12'h500, 12'h520, 12'h540,                     // serial
    12'h700, 12'h720, 12'h740, 12'h760,                     // fifo serial
    12'h560, 12'h580, 12'h5a0};                             // watchdog, refresh

endpackage

// file: rtl/source_priority_select.sv
// Combinational winner search over the pending interrupt sources.
`timescale 1ns/10ps

module source_priority_select (
  // Pending requests and their levels, index 0 first in default order
  input  wire logic [interrupt_priority_pkg::NUM_SRC-1:0]                                  req,
  input  wire logic [interrupt_priority_pkg::NUM_SRC-1:0][interrupt_priority_pkg::LVL_W-1:0] level,
  // Winner
  output logic                                                          found,
  output logic [interrupt_priority_pkg::IDX_W-1:0]                      winIdx,
  output logic [interrupt_priority_pkg::LVL_W-1:0]                      winLevel
);

  // ---------------------------------------------------------------------------
  // Search
  // ---------------------------------------------------------------------------
  // Only a strictly higher level replaces the holder, so equal levels keep the
  // earlier index. Level zero never wins because it starts as the holder level.
  // tie goes earlier
  always_comb begin
    found    = 1'b0;
    winIdx   = '0;
    winLevel = '0;
    for (int i = 0; i < interrupt_priority_pkg::NUM_SRC; i++) begin
      if (req[i] && (level[i] > winLevel)) begin
        found    = 1'b1;
        winIdx   = i[interrupt_priority_pkg::IDX_W-1:0];
        winLevel = level[i];
      end
    end
  end

endmodule

// file: test/core_model.sv
// Behavioural model of the core's exception entry that accepts presented requests.
`timescale 1ns/10ps

module core_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Request from the coder
  input  wire logic       irqValid,
  // Behaviour controls from the bench
  input  wire logic       acceptOn,
  input  wire logic [3:0] acceptDelay,
  // Acceptance back to the coder
  output logic            irqAccept
);
  logic [3:0] waitCount;

  // Waits the chosen number of cycles on a presented request, then pulses acceptance once.
  // A slow core lets the request stand, so the coder must keep it steady meanwhile.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitCount <= 4'h0;
      irqAccept <= 1'b0;
    end else if (irqAccept || !(acceptOn && irqValid)) begin
      waitCount <= 4'h0;
      irqAccept <= 1'b0;
    end else if (waitCount >= acceptDelay) begin
      irqAccept <= 1'b1;
    end else begin
      waitCount <= waitCount + 4'h1;
    end
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the interrupt priority and event code block.
`timescale 1ns/10ps

`define CHECK(what, expVal, gotVal) \
  begin \
    check_count++; \
    if ((gotVal) !== (expVal)) begin \
      miscompares++; \
      $display("mismatch %s expected %h seen %h", what, expVal, gotVal); \
    end \
  end

module testbench;
  // Event codes in default order, index 0 ranks highest.
  localparam logic [11:0] SRC_EXP [37] = '{12'h1c0, 12'h200, 12'h240, 12'h2a0, 12'h300,
    12'h360, 12'h600, 12'h620, 12'h640, 12'h660, 12'h680, 12'h6a0, 12'h780, 12'h7a0,
    12'h7c0, 12'h7e0, 12'h6c0, 12'hb00, 12'hb80, 12'h400, 12'h420, 12'h440, 12'h460,
    12'h480, 12'h4a0, 12'h4c0, 12'h4e0, 12'h500, 12'h520, 12'h540, 12'h700, 12'h720,
    12'h740, 12'h760, 12'h560, 12'h580, 12'h5a0};
  // Each level field: select, shift, code of the group's first source.
  localparam logic [18:0] FIELDS [13] = '{{3'h0, 4'hc, 12'h400}, {3'h0, 4'h8, 12'h420},
    {3'h0, 4'h4, 12'h440}, {3'h0, 4'h0, 12'h480}, {3'h1, 4'hc, 12'h560},
    {3'h1, 4'h8, 12'h580}, {3'h1, 4'h4, 12'h4e0}, {3'h2, 4'hc, 12'h620},
    {3'h2, 4'h8, 12'h640}, {3'h2, 4'h4, 12'h700}, {3'h2, 4'h0, 12'h600},
    {3'h4, 4'h8, 12'hb00}, {3'h4, 4'hc, 12'hb80}};

  logic        clk_sys;
  logic        rst_n;
  logic [36:0] srcReq;
  logic [3:0]  request_pins;
  logic        regWrite;
  logic        regRead;
  logic [2:0]  regSelect;
  logic [15:0] regWriteData;
  logic [15:0] regReadData;
  logic        irqAccept;
  logic        irqValid;
  logic [4:0]  irqLevel;
  logic [11:0] irqCode;
  logic [11:0] event_code_register;
  logic [31:0] handlerVector;
  logic        acceptOn;
  logic [3:0]  acceptDelay;
  int          miscompares;
  int          check_count;
  logic [15:0] rd;
  logic [15:0] v [5];

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk_sys = ~clk_sys;

  interrupt_priority_event_coder DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .nmiReq(srcReq[0]), .request_pins(request_pins),
    .debug_interface(srcReq[6]), .port_unit_request(srcReq[7]),
    .dma_transfer_end(srcReq[15:8]), .dma_address_error(srcReq[16]),
    .timer_underflow({srcReq[18], srcReq[17], srcReq[21], srcReq[20], srcReq[19]}),
    .timer_input_capture(srcReq[22]), .clock_alarm(srcReq[23]),
    .clock_periodic(srcReq[24]), .clock_carry_up(srcReq[25]), .serialReq(srcReq[29:26]),
    .fifoSerialReq(srcReq[33:30]), .watchdog_interval(srcReq[34]),
    .refresh_compare_match(srcReq[35]), .refresh_counter_overflow(srcReq[36]),
    .regWrite(regWrite), .regRead(regRead), .regSelect(regSelect),
    .regWriteData(regWriteData), .regReadData(regReadData), .irqAccept(irqAccept),
    .irqValid(irqValid), .irqLevel(irqLevel), .irqCode(irqCode),
    .event_code_register(event_code_register), .handlerVector(handlerVector));

  core_model core (
    .clk_sys(clk_sys), .rst_n(rst_n), .irqValid(irqValid), .acceptOn(acceptOn),
    .acceptDelay(acceptDelay), .irqAccept(irqAccept));

  // ---------------------------------------------------------------------------
  // Access tasks; each starts and ends 1 ns after a rising edge
  // ---------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // An idle cycle follows each strobe so that no strobe is lowered and raised at once.
  task automatic reg_write(input logic [2:0] sel, input logic [15:0] data);
    regSelect = sel;
    regWriteData = data;
    regWrite = 1'b1;
    step(1);
    regWrite = 1'b0;
    step(1);
  endtask

  task automatic reg_read(input logic [2:0] sel, output logic [15:0] data);
    regSelect = sel;
    regRead = 1'b1;
    step(1);
    regRead = 0;
    data = regReadData;
    step(1);
  endtask

  task automatic program_levels(input logic [15:0] a, b, c, e);
    logic [15:0] junk;
    reg_write(interrupt_priority_pkg::SEL_PRIO_A, a);
    reg_write(interrupt_priority_pkg::SEL_PRIO_B, b);
    reg_write(interrupt_priority_pkg::SEL_PRIO_C, c);
    reg_write(interrupt_priority_pkg::SEL_PRIO_EXT, e);
    reg_read(interrupt_priority_pkg::SEL_PRIO_A, junk);
  endtask

  // A request that is not presented must carry a zero code.
  task automatic check_irq(input logic valid, input logic [4:0] lvl, input logic [11:0] code);
    `CHECK("irqValid", valid, irqValid)
    if (valid) `CHECK("irqLevel", lvl, irqLevel)
    `CHECK("irqCode", code, irqCode)
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    srcReq = '0;
    request_pins = 4'hf;
    {regWrite, regRead, regSelect, regWriteData} = '0;
    {acceptOn, acceptDelay} = '0;
    miscompares = 0;
    check_count = 0;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    step(1);
    for (int s = 0; s < 6; s++) begin
      reg_read(3'(s), rd);
      `CHECK("reset value", (s == 3) ? 16'hda74 : 16'h0000, rd)
    end
    // Level zero masks every module group, and writes wait for a read-back.
    srcReq = ~37'h0 << 6;
    reg_write(interrupt_priority_pkg::SEL_PRIO_A, 16'h0005);
    step(2);
    check_irq(1'b0, 5'h00, 12'h000);
    reg_read(interrupt_priority_pkg::SEL_PRIO_D, rd);
    check_irq(1'b1, 5'h05, 12'h480);
    `CHECK("event reset", 44'h0, {event_code_register, handlerVector})
    acceptOn = 1'b1;
    acceptDelay = 4'h3;
    for (int k = 0; k < 20 && irqAccept !== 1'b1; k++) step(1);
    if (irqAccept !== 1'b1) begin
      miscompares++;
      test_done();
    end
    step(1);
    `CHECK("event code", 12'h480, event_code_register)
    `CHECK("handler", interrupt_priority_pkg::HANDLER_VEC, handlerVector)
    acceptOn = 1'b0;
    // Each field drives its own group: one field at fifteen, the rest at one.
    for (int f = 0; f < 13; f++) begin
      v = '{default: 16'h1111};
      v[FIELDS[f][18:16]] |= 16'h000e << FIELDS[f][15:12];
      program_levels(v[0], v[1], v[2], v[4]);
      check_irq(1'b1, 5'h0f, FIELDS[f][11:0]);
    end
    // Equal levels: every source from i onward pending, so i must win.
    program_levels(16'h7777, 16'h7770, 16'h7777, 16'h7700);
    for (int i = 6; i < 37; i++) begin
      srcReq = ~37'h0 << i;
      step(2);
      check_irq(1'b1, 5'h07, SRC_EXP[i]);
    end
    srcReq = (~37'h0 << 6) | 37'h1;
    request_pins = 4'h0;
    step(4);
    check_irq(1'b1, 5'h10, 12'h1c0);
    srcReq = '0;
    // Encoded pin values, with fifteen meaning idle.
    for (int n = 0; n < 16; n++) begin
      request_pins = 4'(n);
      step(4);
      check_irq(n < 15, 5'(15 - n), (n < 15) ? 12'h200 + 12'h020 * 12'(n) : 12'h000);
    end
    reg_write(interrupt_priority_pkg::SEL_CONTROL, 16'h0080);
    for (int k = 0; k < 4; k++) begin
      request_pins = ~(4'h1 << k);
      step(4);
      check_irq(1'b1, 5'(13 - 3 * k), SRC_EXP[k + 2]);
    end
    reg_write(interrupt_priority_pkg::SEL_PRIO_D, 16'h5555);
    reg_read(interrupt_priority_pkg::SEL_PRIO_D, rd);
    `CHECK("priority d", 16'h5555, rd)
    request_pins = 4'h0;
    step(4);
    check_irq(1'b1, 5'h05, 12'h240);
    // A higher level on the last pin beats the earlier pins, alone or not.
    reg_write(interrupt_priority_pkg::SEL_PRIO_D, 16'h555f);
    reg_read(interrupt_priority_pkg::SEL_PRIO_D, rd);
    step(4);
    check_irq(1'b1, 5'h0f, 12'h360);
    request_pins = 4'h7;
    step(4);
    check_irq(1'b1, 5'h0f, 12'h360);
    test_done();
  end
endmodule
